// ===== design/scta_mem.sv
// Purpose: small single port ram behind the scan wrapped core
// Assumes: write and read share one address, read data registered
// Notes:   reset clears the array too, so test reads never see unknowns
`timescale 1ns/10ps
module scta_mem
   import scta_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   input  wire logic              ce_i,
   input  wire scta_memreq_s      req_i,
   output logic [DATA_W-1:0]      rdata_o
);

   logic [DATA_W-1:0] mem_r [MEM_DEPTH];
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;

   // read returns old contents on a write to the same word
   always_comb begin
      rdata_nxt = rdata_r;
      if (ce_i && req_i.en) begin
         rdata_nxt = mem_r[req_i.addr];
      end
   end

   // cleared array: scan capture of an unwritten word stays defined
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rdata_r <= DAT_RST;
         for (int i = 0; i < MEM_DEPTH; i++) begin
            mem_r[i] <= DAT_RST;
         end
      end else begin
         rdata_r <= rdata_nxt;
         if (ce_i && req_i.en && req_i.we) begin
            mem_r[req_i.addr] <= req_i.wdata;
         end
      end
   end

   assign rdata_o = rdata_r;

endmodule

// ===== design/scta_pkg.sv
// Purpose: shared constants and types for the scan chain test access block
// Assumes: one small functional core whose flops sit on the scan chain, except the overflow flag and the output flops
// Notes:   chain bit 0 is the first stage, fed from the serial test input
package scta_pkg;

   // chain geometry
   localparam int CHAIN_MAX   = 3000;
   localparam int CNT_W       = 8;
   localparam int DATA_W      = 8;
   localparam int ADDR_W      = 4;
   localparam int MEM_DEPTH   = 16;
   localparam int CHAIN_LEN   = CNT_W + 2 * DATA_W;
   localparam int CNT_LSB     = 0;
   localparam int DAT_LSB     = CNT_LSB + CNT_W;
   localparam int RDQ_LSB     = DAT_LSB + DATA_W;
   // stage fed through an inverter from the complement of the one before
   localparam int COMPL_STAGE = DAT_LSB;
   localparam int SYNC_STAGES = 3;

   // reset values, count step and count top
   localparam logic [CNT_W-1:0]  CNT_RST  = 8'h00;
   localparam logic [DATA_W-1:0] DAT_RST  = 8'h00;
   localparam logic [CNT_W-1:0]  CNT_ONE  = 8'h01;
   localparam logic [CNT_W-1:0]  CNT_TOP  = 8'hff;
   localparam logic [5:0]        PINS_IDLE = 6'h2e;

   // operating mode, gray coded along func, shift, capture
   typedef enum logic [1:0] {
      SCTA_FUNC    = 2'b00,
      SCTA_SHIFT   = 2'b01,
      SCTA_CAPTURE = 2'b11
   } scta_mode_e;

   // tester pins as seen after synchronisation
   typedef struct packed {
      logic a_n;
      logic b;
      logic sm_n;
      logic te_n;
      logic cap_n;
      logic serial_test_in;
   } scta_pins_s;

   // the whole scan chain, msb part last
   typedef struct packed {
      logic [DATA_W-1:0] rdq;
      logic [DATA_W-1:0] dat;
      logic [CNT_W-1:0]  cnt;
   } scta_chain_s;

   // request to the little ram
   typedef struct packed {
      logic              en;
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } scta_memreq_s;

endpackage

// ===== design/scta_top.sv
// Purpose: scan wrapped functional core with tester driven shift and capture
// Assumes: tester pins are asynchronous to clock_i and are synchronised
// Notes:   master and slave latches are emulated by edge detected phases
`timescale 1ns/10ps
module scta_top
   import scta_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   input  wire logic              ce_i,
   input  wire logic              link_clock_i,
   input  wire logic              link_rst_n_i,
   input  wire logic              shift_clock_phase_a_n_i,
   input  wire logic              shift_clock_phase_b_i,
   input  wire logic              shift_mode_select_n_i,
   input  wire logic              test_enable_n_i,
   input  wire logic              capture_clock_n_i,
   input  wire logic              serial_test_in_i,
   input  wire logic              count_en_i,
   input  wire logic              clear_i,
   input  wire logic              load_i,
   input  wire logic              data_shift_i,
   input  wire logic [DATA_W-1:0] bus_data_i,
   input  wire logic              bus_drive_i,
   input  wire logic              ram_wr_i,
   input  wire logic [ADDR_W-1:0] ram_addr_i,
   output logic                   serial_test_out_o,
   output logic [CNT_W-1:0]       count_o,
   output logic [DATA_W-1:0]      data_o,
   output logic                   overflow_o,
   output logic [DATA_W-1:0]      bus_data_o,
   output logic                   bus_data_oe_o,
   output logic [DATA_W-1:0]      ram_rdata_o,
   output logic                   shift_mode_o,
   output logic                   capture_mode_o
);

   scta_pins_s            pins_in;
   scta_pins_s            sync1_r, sync1_nxt;
   scta_pins_s            sync2_r, sync2_nxt;
   scta_pins_s            sync3_r, sync3_nxt;
   scta_pins_s            pin_r, pin_nxt;
   scta_pins_s            prev_r, prev_nxt;
   scta_mode_e            mode_r, mode_nxt;
   scta_chain_s           master_r, master_nxt;
   scta_chain_s           slave_r, slave_nxt;
   scta_chain_s           func_nxt;
   scta_memreq_s          mem_req;
   logic [DATA_W-1:0]     mem_rdata;
   logic [CHAIN_LEN-1:0]  master_v;
   logic [CHAIN_LEN-1:0]  slave_v;
   logic [CHAIN_LEN-1:0]  cell_complement_output;
   logic [CHAIN_LEN-1:0]  shift_in;
   logic                  a_pulse;
   logic                  b_pulse;
   logic                  cap_pulse;
   logic                  test_on;
   logic                  ovf_r, ovf_nxt;
   logic                  ovf_o_r, ovf_o_nxt;
   logic [DATA_W-1:0]     bus_d_r, bus_d_nxt;
   logic                  bus_oe_r, bus_oe_nxt;
   logic                  tail_r, tail_nxt;
   logic                  shm_r, shm_nxt;
   logic                  cpm_r, cpm_nxt;
   logic                  lk1_r, lk1_nxt;
   logic                  lk2_r, lk2_nxt;
   logic                  sdo_r, sdo_nxt;

   // six tester inputs enter here, the seventh pin is the serial out
   assign pins_in = {shift_clock_phase_a_n_i, shift_clock_phase_b_i,
                     shift_mode_select_n_i, test_enable_n_i,
                     capture_clock_n_i, serial_test_in_i};

   // three flop synchroniser, a change counts when stages two and three agree
   always_comb begin
      sync1_nxt = sync1_r;
      sync2_nxt = sync2_r;
      sync3_nxt = sync3_r;
      pin_nxt   = pin_r;
      prev_nxt  = prev_r;
      if (ce_i) begin
         sync1_nxt = pins_in;
         sync2_nxt = sync1_r;
         sync3_nxt = sync2_r;
         pin_nxt   = (sync2_r == sync3_r) ? sync2_r : pin_r;
         prev_nxt  = pin_r;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         sync1_r <= PINS_IDLE;
         sync2_r <= PINS_IDLE;
         sync3_r <= PINS_IDLE;
         pin_r   <= PINS_IDLE;
         prev_r  <= PINS_IDLE;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         sync3_r <= sync3_nxt;
         pin_r   <= pin_nxt;
         prev_r  <= prev_nxt;
      end
   end

   // clock pulses are edges of the filtered tester clocks
   assign a_pulse   = prev_r.a_n & ~pin_r.a_n;
   assign b_pulse   = ~prev_r.b & pin_r.b;
   assign cap_pulse = prev_r.cap_n & ~pin_r.cap_n;
   // test enable stays: the overflow flag and the clear need isolating
   assign test_on   = ~pin_r.te_n;

   // mode follows the select pins; shift select wins over test enable
   always_comb begin
      mode_nxt = mode_r;
      if (ce_i) begin
         case (mode_r)
            SCTA_FUNC: begin
               if (!pin_r.sm_n) begin
                  mode_nxt = SCTA_SHIFT;
               end else if (test_on) begin
                  mode_nxt = SCTA_CAPTURE;
               end
            end
            SCTA_SHIFT: begin
               if (pin_r.sm_n) begin
                  mode_nxt = test_on ? SCTA_CAPTURE : SCTA_FUNC;
               end
            end
            SCTA_CAPTURE: begin
               if (!pin_r.sm_n) begin
                  mode_nxt = SCTA_SHIFT;
               end else if (!test_on) begin
                  mode_nxt = SCTA_FUNC;
               end
            end
            default: begin
               mode_nxt = SCTA_FUNC;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         mode_r <= SCTA_FUNC;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // chain wiring; one stage takes its input from a complement output
   assign master_v               = master_r;
   assign slave_v                = slave_r;
   assign cell_complement_output = ~slave_v;

   generate
      for (genvar gi = 0; gi < CHAIN_LEN; gi++) begin : g_stage
         if (gi == 0) begin : g_first
            assign shift_in[gi] = pin_r.serial_test_in;
         end else if (gi == COMPL_STAGE) begin : g_inv
            assign shift_in[gi] = ~cell_complement_output[gi-1];
         end else begin : g_true
            assign shift_in[gi] = slave_v[gi-1];
         end
      end
   endgenerate

   // ram: test enable hands address and write enable to scan flops
   always_comb begin
      mem_req.en    = 1'b1;
      mem_req.we    = ram_wr_i & (mode_r == SCTA_FUNC);
      mem_req.addr  = ram_addr_i;
      mem_req.wdata = slave_r.dat + mem_rdata;
      if (test_on) begin
         mem_req.addr  = slave_r.cnt[ADDR_W-1:0];
         mem_req.we    = cap_pulse & (mode_r == SCTA_CAPTURE)
                       & slave_r.dat[DATA_W-1];
         mem_req.wdata = slave_r.rdq;
      end
      if (mode_r == SCTA_SHIFT) begin
         mem_req.we = 1'b0;
      end
   end

   scta_mem u_mem (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .ce_i    (ce_i),
      .req_i   (mem_req),
      .rdata_o (mem_rdata)
   );

   // functional next state; clear is blocked under test since it acts
   // outside the chain and would upset captured data
   always_comb begin
      func_nxt     = slave_r;
      func_nxt.rdq = mem_rdata;
      if (clear_i && !test_on) begin
         func_nxt.cnt = CNT_RST;
      end else if (count_en_i) begin
         func_nxt.cnt = slave_r.cnt + CNT_ONE;
      end
      if (load_i) begin
         func_nxt.dat = bus_data_i;
      end else if (data_shift_i) begin
         func_nxt.dat = {slave_r.dat[DATA_W-2:0], pin_r.serial_test_in};
      end
   end

   // core state: master and slave are the scan stages; the overflow flag and the output flops are not
   always_comb begin
      master_nxt = master_r;
      slave_nxt  = slave_r;
      ovf_nxt    = ovf_r;
      ovf_o_nxt  = ovf_o_r;
      bus_d_nxt  = bus_d_r;
      bus_oe_nxt = bus_oe_r;
      tail_nxt   = tail_r;
      shm_nxt    = shm_r;
      cpm_nxt    = cpm_r;
      if (ce_i) begin
         case (mode_r)
            SCTA_SHIFT: begin
               if (a_pulse) begin
                  master_nxt = shift_in;
               end
               if (b_pulse) begin
                  slave_nxt = master_r;
               end
            end
            SCTA_CAPTURE: begin
               // functional clock held low, only the capture pulse updates
               if (cap_pulse) begin
                  master_nxt = func_nxt;
                  slave_nxt  = func_nxt;
               end
            end
            default: begin
               master_nxt = func_nxt;
               slave_nxt  = func_nxt;
            end
         endcase
         // non-scan flag frozen and masked under test; set beats clear
         if (!test_on && mode_r == SCTA_FUNC) begin
            if (count_en_i && slave_r.cnt == CNT_TOP) begin
               ovf_nxt = 1'b1;
            end else if (clear_i) begin
               ovf_nxt = 1'b0;
            end
         end
         ovf_o_nxt  = ovf_r & ~test_on;
         bus_d_nxt  = slave_r.dat;
         bus_oe_nxt = bus_drive_i & (mode_nxt != SCTA_SHIFT);
         tail_nxt   = ~cell_complement_output[CHAIN_LEN-1];
         shm_nxt    = (mode_nxt == SCTA_SHIFT);
         cpm_nxt    = (mode_nxt == SCTA_CAPTURE);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         master_r <= {DAT_RST, DAT_RST, CNT_RST};
         slave_r  <= {DAT_RST, DAT_RST, CNT_RST};
         ovf_r    <= 1'b0;
         ovf_o_r  <= 1'b0;
         bus_d_r  <= DAT_RST;
         bus_oe_r <= 1'b0;
         tail_r   <= 1'b0;
         shm_r    <= 1'b0;
         cpm_r    <= 1'b0;
      end else begin
         master_r <= master_nxt;
         slave_r  <= slave_nxt;
         ovf_r    <= ovf_nxt;
         ovf_o_r  <= ovf_o_nxt;
         bus_d_r  <= bus_d_nxt;
         bus_oe_r <= bus_oe_nxt;
         tail_r   <= tail_nxt;
         shm_r    <= shm_nxt;
         cpm_r    <= cpm_nxt;
      end
   end

   // serial out crosses into the link clock by two flops, then a pin flop
   always_comb begin
      lk1_nxt = tail_r;
      lk2_nxt = lk1_r;
      sdo_nxt = lk2_r;
   end

   always_ff @(posedge link_clock_i) begin
      if (!link_rst_n_i) begin
         lk1_r <= 1'b0;
         lk2_r <= 1'b0;
         sdo_r <= 1'b0;
      end else begin
         lk1_r <= lk1_nxt;
         lk2_r <= lk2_nxt;
         sdo_r <= sdo_nxt;
      end
   end

   assign serial_test_out_o = sdo_r;
   assign count_o           = slave_r.cnt;
   assign data_o            = slave_r.dat;
   assign overflow_o        = ovf_o_r;
   assign bus_data_o        = bus_d_r;
   assign bus_data_oe_o     = bus_oe_r;
   assign ram_rdata_o       = mem_rdata;
   assign shift_mode_o      = shm_r;
   assign capture_mode_o    = cpm_r;

   default clocking cb_sys @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   property p_shift_a;
      (mode_r == SCTA_SHIFT && a_pulse && ce_i)
         |=> master_v == $past(shift_in);
   endproperty
   a_shift_a: assert property (p_shift_a)
      else $error("phase a did not load master latches");

   property p_shift_b;
      (mode_r == SCTA_SHIFT && b_pulse && ce_i)
         |=> slave_v == $past(master_v);
   endproperty
   a_shift_b: assert property (p_shift_b)
      else $error("phase b did not move master into slave");

   property p_first;
      (mode_r == SCTA_SHIFT && a_pulse && ce_i)
         |=> master_v[0] == $past(pin_r.serial_test_in);
   endproperty
   a_first: assert property (p_first)
      else $error("first stage did not take serial input");

   property p_inv;
      (mode_r == SCTA_SHIFT && a_pulse && ce_i)
         |=> master_v[COMPL_STAGE] == $past(slave_v[COMPL_STAGE-1]);
   endproperty
   a_inv: assert property (p_inv)
      else $error("inverted stage shifted inverted data");

   property p_mode_shift;
      (!pin_r.sm_n && ce_i) |=> mode_r == SCTA_SHIFT && shift_mode_o;
   endproperty
   a_mode_shift: assert property (p_mode_shift)
      else $error("low select did not enter shift mode");

   property p_mode_cap;
      (pin_r.sm_n && test_on && ce_i) |=> mode_r == SCTA_CAPTURE;
   endproperty
   a_mode_cap: assert property (p_mode_cap)
      else $error("high select with test on is not capture");

   property p_cap_hold;
      (mode_r == SCTA_CAPTURE && !cap_pulse) |=> $stable(slave_v);
   endproperty
   a_cap_hold: assert property (p_cap_hold)
      else $error("cells changed in capture without a pulse");

   property p_cap;
      (mode_r == SCTA_CAPTURE && cap_pulse && ce_i)
         |=> slave_r == $past(func_nxt);
   endproperty
   a_cap: assert property (p_cap)
      else $error("capture pulse did not load functional data");

   property p_iso;
      (test_on && ce_i) |=> !overflow_o && $stable(ovf_r);
   endproperty
   a_iso: assert property (p_iso)
      else $error("non-scan flag not isolated under test");

   property p_ram;
      test_on |-> mem_req.wdata == slave_r.rdq
         && mem_req.addr == slave_r.cnt[ADDR_W-1:0];
   endproperty
   a_ram: assert property (p_ram)
      else $error("ram not under scan control in test");

   property p_oe;
      (!pin_r.sm_n && ce_i) |=> !bus_data_oe_o;
   endproperty
   a_oe: assert property (p_oe)
      else $error("bus driver enabled during shift");

   property p_tail;
      ce_i |=> tail_r == $past(slave_v[CHAIN_LEN-1]);
   endproperty
   a_tail: assert property (p_tail)
      else $error("serial out source is not the last stage");

endmodule

// ===== tb/scta_tester.sv
// Purpose: tester model driving the scan pins of the scan wrapped core
// Assumes: each pin level is held 8 clocks, well above the pin filter span
// Notes:   tasks start and end just after a clock edge, clock pins idle between
`timescale 1ns/10ps
module scta_tester
   import scta_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic serial_test_out_i,
   output logic      phase_a_n_o,
   output logic      phase_b_o,
   output logic      mode_sel_n_o,
   output logic      test_en_n_o,
   output logic      capture_n_o,
   output logic      serial_in_o
);
   localparam int HOLD = 8;

   // idle levels: no clock active, no test mode
   initial begin
      phase_a_n_o  = 1'b1;
      phase_b_o    = 1'b0;
      mode_sel_n_o = 1'b1;
      test_en_n_o  = 1'b1;
      capture_n_o  = 1'b1;
      serial_in_o  = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge clock_i);
   endtask

   // mode pins move only while both shift clocks and capture clock idle
   task automatic set_mode(input logic sm_n, input logic te_n);
      mode_sel_n_o <= sm_n;
      test_en_n_o  <= te_n;
      hold(HOLD);
   endtask

   // one phase pair; output is read before the new bit moves along
   task automatic pair(input logic din, output logic dout);
      dout = serial_test_out_i;
      serial_in_o <= din;
      phase_a_n_o <= 1'b0;
      hold(HOLD);
      phase_a_n_o <= 1'b1;
      hold(HOLD);
      phase_b_o <= 1'b1;
      hold(HOLD);
      phase_b_o <= 1'b0;
      // long tail so the link domain output settles before next read
      hold(3 * HOLD);
   endtask

   // single capture clock pulse, active low
   task automatic capture();
      capture_n_o <= 1'b0;
      hold(HOLD);
      capture_n_o <= 1'b1;
      hold(HOLD);
   endtask
endmodule

// ===== tb/scta_top_test.sv
// Purpose: self checking bench for the scan wrapped core
// Assumes: tester model drives scan pins, bench drives functional pins
// Notes:   one task per scenario, each judges its own results
`timescale 1ns/10ps
module scta_top_test
   import scta_pkg::*;
;
   localparam logic [23:0] PAT_A = 24'ha53c96;
   localparam logic [23:0] PAT_B = 24'h3cc3a7;
   localparam int          LIMIT = 20000;

   logic              clock_i = 1'b0;
   logic              link_clock_i = 1'b0;
   logic              rst_n_i = 1'b0;
   logic              count_en_i = 1'b0;
   logic              clear_i = 1'b0;
   logic              load_i = 1'b0;
   logic [DATA_W-1:0] bus_data_i = 8'h00;
   logic              bus_drive_i = 1'b0;
   logic              ram_wr_i = 1'b0;
   logic              data_shift_i = 1'b0;
   logic              a_n, b, sm_n, te_n, cap_n, serial_test_in, serial_test_out, oe;
   logic [CNT_W-1:0]  count;
   logic [DATA_W-1:0] data, bus_q, ram_q;
   logic              ovf, sh_mode, cap_mode;
   int                bad_count = 0;
   int                compares = 0;
   int                cycles = 0;

   // system clock 25 ns, link clock 160 ns on an unrelated phase
   initial begin
      forever #12.5 clock_i = ~clock_i;
   end
   initial begin
      #37;
      forever #80 link_clock_i = ~link_clock_i;
   end

   scta_top i_dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
      .link_clock_i(link_clock_i), .link_rst_n_i(rst_n_i),
      .shift_clock_phase_a_n_i(a_n), .shift_clock_phase_b_i(b),
      .shift_mode_select_n_i(sm_n), .test_enable_n_i(te_n),
      .capture_clock_n_i(cap_n), .serial_test_in_i(serial_test_in),
      .count_en_i(count_en_i), .clear_i(clear_i), .load_i(load_i),
      .data_shift_i(data_shift_i), .bus_data_i(bus_data_i),
      .bus_drive_i(bus_drive_i), .ram_wr_i(ram_wr_i),
      .ram_addr_i(4'h3), .serial_test_out_o(serial_test_out), .count_o(count),
      .data_o(data), .overflow_o(ovf), .bus_data_o(bus_q),
      .bus_data_oe_o(oe), .ram_rdata_o(ram_q), .shift_mode_o(sh_mode),
      .capture_mode_o(cap_mode));

   scta_tester i_tester (
      .clock_i(clock_i), .serial_test_out_i(serial_test_out), .phase_a_n_o(a_n),
      .phase_b_o(b), .mode_sel_n_o(sm_n), .test_en_n_o(te_n),
      .capture_n_o(cap_n), .serial_in_o(serial_test_in));

   task automatic test_done();
      if (bad_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // a hang ends the run with a mismatch
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         test_done();
      end
   end

   // first bit sent ends at the far stage; returns the previous chain
   task automatic shift_word(input logic [23:0] din, output logic [23:0] q);
      logic bit_o;
      for (int k = 23; k >= 0; k--) begin
         i_tester.pair(din[k], bit_o);
         q[k] = bit_o;
      end
   endtask

   task automatic t_reset();
      check({count, data, ovf, oe, sh_mode, cap_mode, serial_test_out}, 24'h0);
   endtask

   // functional mode: bus load, then a wrap that meets a clear
   task automatic t_func();
      i_tester.set_mode(1'b1, 1'b1);
      check({sh_mode, cap_mode}, 24'h0);
      clear_i     <= 1'b1;
      load_i      <= 1'b1;
      bus_drive_i <= 1'b1;
      bus_data_i  <= 8'h5a;
      @(posedge clock_i);
      clear_i <= 1'b0;
      load_i  <= 1'b0;
      repeat (3) @(posedge clock_i);
      check({count, data}, 24'h00005a);
      check({bus_q, oe}, {8'h5a, 1'b1});
      count_en_i <= 1'b1;
      repeat (255) @(posedge clock_i);
      // clear lands on the wrapping edge: the flag must still set
      clear_i <= 1'b1;
      @(posedge clock_i);
      clear_i    <= 1'b0;
      count_en_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      check({count, ovf}, {8'h00, 1'b1});
   endtask

   // shift in a word, then shift it out while loading the next
   task automatic t_shift();
      logic [23:0] got;
      count_en_i  <= 1'b1;
      i_tester.set_mode(1'b0, 1'b0);
      check({sh_mode, cap_mode, oe}, 24'h4);
      check(ovf, 1'b0);
      shift_word(PAT_A, got);
      check({data, count}, PAT_A[15:0]);
      shift_word(PAT_B, got);
      check(got, PAT_A);
      check({data, count}, PAT_B[15:0]);
   endtask

   // capture mode: phases ignored, system clock gated, one capture
   task automatic t_capture();
      logic [23:0] got;
      logic        bit_o;
      clear_i <= 1'b1;
      i_tester.set_mode(1'b1, 1'b0);
      check({sh_mode, cap_mode}, 24'h1);
      check({data, count}, PAT_B[15:0]);
      i_tester.pair(1'b1, bit_o);
      check({data, count}, PAT_B[15:0]);
      i_tester.capture();
      check({data, count}, {PAT_B[15:8], PAT_B[7:0] + 8'h01});
      check(ovf, 1'b0);
      clear_i <= 1'b0;
      i_tester.set_mode(1'b0, 1'b0);
      shift_word(24'h0, got);
      check(got, {DAT_RST, PAT_B[15:8], PAT_B[7:0] + 8'h01});
   endtask

   // back to functional mode: held flag, clear, ram write, user shift
   task automatic t_clear();
      i_tester.set_mode(1'b1, 1'b1);
      check({sh_mode, cap_mode, ovf}, 24'h1);
      count_en_i <= 1'b0;
      clear_i    <= 1'b1;
      load_i     <= 1'b1;
      bus_data_i <= 8'h21;
      @(posedge clock_i);
      clear_i  <= 1'b0;
      load_i   <= 1'b0;
      ram_wr_i <= 1'b1;
      @(posedge clock_i);
      ram_wr_i     <= 1'b0;
      data_shift_i <= 1'b1;
      @(posedge clock_i);
      data_shift_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      check({count, ovf}, {8'h00, 1'b0});
      check({data, ram_q}, 16'h4221);
   endtask

   // reset held 5 cycles, then scenarios in tester order
   initial begin
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      t_reset();
      t_func();
      t_shift();
      t_capture();
      t_clear();
      test_done();
   end
endmodule
